//--- core/pw_err_hc_defs.vh
// Register map, field layout and reset values for the posted-write error
// capture, vendor identity and upper host control register block.
// Assumes byte addressing on a 32-bit AXI4-Lite bus, aligned words only.
`ifndef PW_ERR_HC_DEFS_VH
`define PW_ERR_HC_DEFS_VH

// Register byte offsets
`define OFS_FAILED_WRITE 8'h3c
`define OFS_VENDOR_IDENTITY 8'h40
`define OFS_HC_SET 8'h50
`define OFS_HC_CLEAR 8'h54
`define OFS_IRQ_STATUS 8'h60
`define OFS_IRQ_MASK 8'h64
`define ADDR_BITS 8

// Error capture field positions
`define FW_BUS_HI 31
`define FW_BUS_LO 22
`define FW_NODE_HI 21
`define FW_NODE_LO 16
`define FW_OFS_HI 15
`define FW_OFS_LO 0

// Host control bit positions
`define HC_SWAP_DISABLE 30
`define HC_PHY_CONFIG_PERMIT 23

// Reset values
`define FAILED_WRITE_RST 32'h0000_0000
`define SWAP_DISABLE_RST 1'h0
`define PERMIT_RST 1'h0
`define IRQ_STATUS_RST 2'h0
`define IRQ_MASK_RST 2'h0

// Identity code returned at the vendor offset; the value is arbitrary
`define VENDOR_IDENTITY_VALUE 32'h5a5a_0001

// Interrupt status bit positions
`define IRQ_FAILED_WRITE 0
`define IRQ_PERMIT_LOADED 1

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- core/pw_err_hc_regs.v
// Posted-write error capture, vendor identity and host control bits 31..23,
// reached over an AXI4-Lite slave, with a level interrupt.
// Assumes error events and EEPROM load pulses are on i_clock already.
// Assumes control bits 22..0 and the lower offset word live in other blocks.
// What this block does
// - Failed posted write updates the capture register
// - Upper half holds bus and node number
// - Lower half holds destination offset upper bits
// - Capture is read-only, hardware-updated, undefined after reset
// - Vendor identity reads fixed constant, writes ignored
// - Set address sets ones, clear address clears
// - Bits 31 and 29..24 read zero always
// - Bit 30 selects data byte swap
// - Bit 23 loaded from EEPROM, clear only
`timescale 1ns/100ps
`include "pw_err_hc_defs.vh"

module pw_err_hc_regs (
  input wire i_clock,
  input wire i_rst,
  // AXI4-Lite write address
  input wire i_s_axi_awvalid,
  output reg o_s_axi_awready,
  input wire [31:0] i_s_axi_awaddr,
  // Protection attributes are accepted and not used
  input wire [2:0] i_s_axi_awprot,
  // AXI4-Lite write data
  input wire i_s_axi_wvalid,
  output reg o_s_axi_wready,
  input wire [31:0] i_s_axi_wdata,
  input wire [3:0] i_s_axi_wstrb,
  // AXI4-Lite write response
  output reg o_s_axi_bvalid,
  input wire i_s_axi_bready,
  output reg [1:0] o_s_axi_bresp,
  // AXI4-Lite read address
  input wire i_s_axi_arvalid,
  output reg o_s_axi_arready,
  input wire [31:0] i_s_axi_araddr,
  // Protection attributes are accepted and not used
  input wire [2:0] i_s_axi_arprot,
  // AXI4-Lite read data
  output reg o_s_axi_rvalid,
  input wire i_s_axi_rready,
  output reg [31:0] o_s_axi_rdata,
  output reg [1:0] o_s_axi_rresp,
  // Posted-write failure report, one-cycle strobe with its payload
  input wire i_pw_fail,
  input wire [9:0] i_pw_fail_bus,
  input wire [5:0] i_pw_fail_node,
  input wire [15:0] i_pw_fail_offset_hi,
  // EEPROM loader, one-cycle strobe with the loaded permit value
  input wire i_eeprom_load,
  input wire i_eeprom_permit,
  // Control outputs to the rest of the controller
  output reg o_swap_disable,
  output reg o_phy_enhance_config_permit,
  output reg o_irq
);

  // Capture register, one word so all fields move together
  reg [31:0] failed_write_ff;
  reg [31:0] nxt_failed_write;
  // Upper host control flags
  reg swap_disable_ff;
  reg permit_ff;
  reg nxt_swap_disable;
  reg nxt_permit;
  // Sticky interrupt status and mask
  reg [1:0] irq_status_ff;
  reg [1:0] irq_mask_ff;
  reg [1:0] nxt_irq_status;
  reg [1:0] nxt_irq_mask;
  // Captured write address and data
  // Held until both halves are in, so either may come first
  reg aw_held_ff;
  reg w_held_ff;
  reg [`ADDR_BITS-1:0] aw_addr_ff;
  reg [31:0] w_data_ff;
  reg [3:0] w_strb_ff;
  // Address decode helpers
  wire [`ADDR_BITS-1:0] ar_ofs;
  wire ar_aligned;
  wire do_write;
  wire do_read;
  wire wr_set;
  wire wr_clr;
  wire wr_mask;
  wire rd_status;
  // Readback words
  wire [31:0] hc_word;
  reg [31:0] rd_word;
  reg rd_ok;

  // Read decode uses the live address, which the master holds while waiting
  assign ar_ofs = i_s_axi_araddr[`ADDR_BITS-1:0];
  // Upper address bits must be zero, else the access is unmapped
  assign ar_aligned = (i_s_axi_araddr[31:`ADDR_BITS] == 24'h00_0000);
  // Write fires once both halves are held and no response is pending
  assign do_write = aw_held_ff & w_held_ff & ~o_s_axi_bvalid;
  // A read is taken on the edge where valid meets ready
  assign do_read = i_s_axi_arvalid & o_s_axi_arready;
  // Each write strobe needs the held address to match exactly
  assign wr_set = do_write & (aw_addr_ff == `OFS_HC_SET);
  assign wr_clr = do_write & (aw_addr_ff == `OFS_HC_CLEAR);
  assign wr_mask = do_write & (aw_addr_ff == `OFS_IRQ_MASK);
  // Only an in-range status read clears the sticky bits
  assign rd_status = do_read & ar_aligned & (ar_ofs == `OFS_IRQ_STATUS);

  // Readback word: reserved bits tied to zero
  assign hc_word = {
    1'b0, // Bit 31 reserved
    swap_disable_ff, // Bit 30
    6'h00, // Bits 29..24 reserved
    permit_ff, // Bit 23
    23'h00_0000 // Bits 22..0 belong to another block
  };

  // Write channel capture; address and data may arrive in either order
  always @(posedge i_clock) begin
    if (i_rst) begin
      // Channels start idle; readiness returns one edge after release
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0000_0000;
      w_strb_ff <= 4'h0;
      o_s_axi_awready <= 1'b0;
      o_s_axi_wready <= 1'b0;
      o_s_axi_bvalid <= 1'b0;
      o_s_axi_bresp <= `RESP_OKAY;
    end else begin
      // Ready is offered only while that half is still empty
      // The take edge drops ready, so a held valid is not taken twice
      o_s_axi_awready <= ~aw_held_ff & ~(i_s_axi_awvalid & o_s_axi_awready);
      o_s_axi_wready <= ~w_held_ff & ~(i_s_axi_wvalid & o_s_axi_wready);
      if (i_s_axi_awvalid & o_s_axi_awready) begin
        // Address half taken; kept until the write is applied
        aw_held_ff <= 1'b1;
        // Out-of-range upper bits map to an address that decodes nowhere
        aw_addr_ff <= (i_s_axi_awaddr[31:`ADDR_BITS] == 24'h00_0000) ?
                      i_s_axi_awaddr[`ADDR_BITS-1:0] : 8'hff;
      end
      if (i_s_axi_wvalid & o_s_axi_wready) begin
        // Data half taken, strobes kept with it
        w_held_ff <= 1'b1;
        w_data_ff <= i_s_axi_wdata;
        w_strb_ff <= i_s_axi_wstrb;
      end
      if (do_write) begin
        // Both halves present: apply now and raise the response
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        o_s_axi_awready <= 1'b0;
        o_s_axi_wready <= 1'b0;
        o_s_axi_bvalid <= 1'b1;
        // Read-only registers accept and ignore writes; unmapped errors
        case (aw_addr_ff)
          `OFS_FAILED_WRITE, `OFS_VENDOR_IDENTITY, `OFS_HC_SET, `OFS_HC_CLEAR,
          `OFS_IRQ_STATUS, `OFS_IRQ_MASK: o_s_axi_bresp <= `RESP_OKAY;
          // Anything else is unmapped and reports an error
          default: o_s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (o_s_axi_bvalid & i_s_axi_bready) begin
        // Master took the response; the next write may apply
        o_s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control flag next values: set, clear and EEPROM load
  always @* begin
    // Hold by default so idle cycles keep the flags
    nxt_swap_disable = swap_disable_ff;
    nxt_permit = permit_ff;
    // Set and clear sit at separate addresses, so no write does both
    // Byte lane 3 carries bits 31..24, lane 2 carries bit 23
    if (wr_set & w_strb_ff[3] & w_data_ff[`HC_SWAP_DISABLE]) begin
      nxt_swap_disable = 1'b1;
    end
    if (wr_clr & w_strb_ff[3] & w_data_ff[`HC_SWAP_DISABLE]) begin
      nxt_swap_disable = 1'b0;
    end
    // Permit can only be cleared by software; set-address writes ignored
    if (wr_clr & w_strb_ff[2] & w_data_ff[`HC_PHY_CONFIG_PERMIT]) begin
      nxt_permit = 1'b0;
    end
    // EEPROM load wins over a same-cycle software clear
    if (i_eeprom_load) begin
      nxt_permit = i_eeprom_permit;
    end
  end

  // Capture of a failed posted write, all fields in one step
  // A single word register means a read can never mix two failures
  always @* begin
    // Hold the last failure until the next one replaces it
    nxt_failed_write = failed_write_ff;
    if (i_pw_fail) begin
      // Requester bus and node in the upper half
      nxt_failed_write[`FW_BUS_HI:`FW_BUS_LO] = i_pw_fail_bus;
      nxt_failed_write[`FW_NODE_HI:`FW_NODE_LO] = i_pw_fail_node;
      // Upper destination offset bits in the lower half
      nxt_failed_write[`FW_OFS_HI:`FW_OFS_LO] = i_pw_fail_offset_hi;
    end
  end

  // Interrupt status: events set, a read clears, set wins the tie
  always @* begin
    nxt_irq_status = irq_status_ff;
    // A read of the status word clears every bit
    if (rd_status) begin
      nxt_irq_status = 2'h0;
    end
    // Events come after the clear, so one landing on the read is not lost
    if (i_pw_fail) begin
      nxt_irq_status[`IRQ_FAILED_WRITE] = 1'b1;
    end
    // Bit 1 records that the loader has delivered the permit value
    if (i_eeprom_load) begin
      nxt_irq_status[`IRQ_PERMIT_LOADED] = 1'b1;
    end
  end

  // Interrupt mask: plain read-write bits behind the lowest byte lane
  always @* begin
    nxt_irq_mask = irq_mask_ff;
    if (wr_mask & w_strb_ff[0]) begin
      // Only the two defined bits are kept
      nxt_irq_mask = w_data_ff[1:0];
    end
  end

  // State registers
  always @(posedge i_clock) begin
    if (i_rst) begin
      // Capture content is don't-care after reset; zero keeps sims clean
      failed_write_ff <= `FAILED_WRITE_RST;
      // Swap flag has no defined start value; zero gives a known one
      swap_disable_ff <= `SWAP_DISABLE_RST;
      // Permit stays low until the loader reports in
      permit_ff <= `PERMIT_RST;
      irq_status_ff <= `IRQ_STATUS_RST;
      irq_mask_ff <= `IRQ_MASK_RST;
      o_swap_disable <= `SWAP_DISABLE_RST;
      o_phy_enhance_config_permit <= `PERMIT_RST;
      o_irq <= 1'b0;
    end else begin
      failed_write_ff <= nxt_failed_write;
      swap_disable_ff <= nxt_swap_disable;
      permit_ff <= nxt_permit;
      irq_status_ff <= nxt_irq_status;
      irq_mask_ff <= nxt_irq_mask;
      o_swap_disable <= nxt_swap_disable;
      // Downstream enhancement logic gates on this copy
      o_phy_enhance_config_permit <= nxt_permit;
      // Next values feed the line, so it is not a cycle behind the status
      o_irq <= |(nxt_irq_status & nxt_irq_mask);
    end
  end

  // Read data mux
  always @* begin
    rd_word = 32'h0000_0000;
    rd_ok = ar_aligned;
    // Decoded from the live address and latched on the take edge
    case (ar_ofs)
      // Last stored failure; undefined until the first one arrives
      `OFS_FAILED_WRITE: rd_word = failed_write_ff;
      // Fixed identity code, no writable state behind it
      `OFS_VENDOR_IDENTITY: rd_word = `VENDOR_IDENTITY_VALUE;
      // Both control addresses return the same flag word
      `OFS_HC_SET, `OFS_HC_CLEAR: rd_word = hc_word;
      // Status and mask carry two bits each
      `OFS_IRQ_STATUS: rd_word = {30'h0, irq_status_ff};
      `OFS_IRQ_MASK: rd_word = {30'h0, irq_mask_ff};
      // Unmapped offsets read zero and answer with an error
      default: rd_ok = 1'b0;
    endcase
  end

  // Read channel: one read in flight, answer one cycle after the take
  always @(posedge i_clock) begin
    if (i_rst) begin
      // Idle with no answer pending
      o_s_axi_arready <= 1'b0;
      o_s_axi_rvalid <= 1'b0;
      o_s_axi_rdata <= 32'h0000_0000;
      o_s_axi_rresp <= `RESP_OKAY;
    end else begin
      // Ready drops on the take edge and stays low while the answer stands
      o_s_axi_arready <= ~o_s_axi_rvalid & ~do_read;
      if (do_read) begin
        // Unmapped reads return zero data with an error code
        o_s_axi_rvalid <= 1'b1;
        o_s_axi_rdata <= rd_ok ? rd_word : 32'h0000_0000;
        o_s_axi_rresp <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (o_s_axi_rvalid & i_s_axi_rready) begin
        // Answer retired on the rready edge
        o_s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // pw_err_hc_regs

//--- sim/posted_write_error_and_host_control_bench.sv
// Self-checking bench for the error capture and host control block.
// Assumes the design and its defines header are compiled alongside.
`timescale 1ns/100ps
`include "pw_err_hc_defs.vh"
module posted_write_error_and_host_control_bench;
  reg clock = 1'b0;
  reg rst = 1'b1;
  // Bus master side
  reg awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0;
  reg [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0;
  reg [3:0] ws = 4'hf;
  // Events; pv packs bus, node and offset like the capture word
  reg pf = 1'b0, el = 1'b0, ep = 1'b0;
  reg [31:0] pv = 32'h0;
  wire awr, wrd, bv, arr, rv, swp, prm, irq;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer failures = 0, checks_done = 0;
  pw_err_hc_regs u_pw_err_hc_regs (
    .i_clock(clock), .i_rst(rst),
    .i_s_axi_awvalid(awv), .o_s_axi_awready(awr), .i_s_axi_awaddr(awa), .i_s_axi_awprot(3'h0),
    .i_s_axi_wvalid(wv), .o_s_axi_wready(wrd), .i_s_axi_wdata(wd), .i_s_axi_wstrb(ws),
    .o_s_axi_bvalid(bv), .i_s_axi_bready(br), .o_s_axi_bresp(bresp),
    .i_s_axi_arvalid(arv), .o_s_axi_arready(arr), .i_s_axi_araddr(ara), .i_s_axi_arprot(3'h0),
    .o_s_axi_rvalid(rv), .i_s_axi_rready(rr), .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp),
    .i_pw_fail(pf), .i_pw_fail_bus(pv[31:22]), .i_pw_fail_node(pv[21:16]),
    .i_pw_fail_offset_hi(pv[15:0]), .i_eeprom_load(el), .i_eeprom_permit(ep),
    .o_swap_disable(swp), .o_phy_enhance_config_permit(prm), .o_irq(irq));
  initial begin
    forever #5 clock = ~clock;
  end
  task chk(input [8*6:1] nm, input [31:0] seen, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("mismatch %0s expected %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // One bus access; d is write data or expected read data
  task xfer(input w, input [7:0] a, input [31:0] d, input [1:0] er);
    integer n;
    reg ta, tw, tr, tb;
    reg [1:0] rs;
    reg [31:0] rdv;
    begin
      @(posedge clock);
      if (w) begin
        awa <= {24'h0, a};
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
      end else begin
        ara <= {24'h0, a};
        arv <= 1'b1;
        rr <= 1'b1;
      end
      tb = 1'b0;
      // Sample mid-cycle, act on the next edge, so no race with the design
      for (n = 0; n < 40 && !tb; n = n + 1) begin
        @(negedge clock);
        ta = awv & awr;
        tw = wv & wrd;
        tr = arv & arr;
        tb = w ? bv : rv;
        rs = w ? bresp : rresp;
        rdv = rdata;
        @(posedge clock);
        if (ta)
          awv <= 1'b0;
        if (tw)
          wv <= 1'b0;
        if (tr)
          arv <= 1'b0;
      end
      br <= 1'b0;
      rr <= 1'b0;
      if (!tb) begin
        failures = failures + 1;
        results;
      end
      chk("resp", {30'h0, rs}, {30'h0, er});
      if (!w)
        chk("rdata", rdv, d);
    end
  endtask
  // One-cycle pulse: failed write if f, else EEPROM load of p
  task evt(input f, input [31:0] v, input p);
    begin
      @(posedge clock);
      pf <= f;
      el <= !f;
      pv <= v;
      ep <= p;
      @(posedge clock);
      pf <= 1'b0;
      el <= 1'b0;
      @(negedge clock);
    end
  endtask
  initial begin
    repeat (6) @(posedge clock);
    rst <= 1'b0;
    xfer(1, 8'h40, 32'hffffffff, 2'h0);
    xfer(0, 8'h40, `VENDOR_IDENTITY_VALUE, 2'h0);
    // Bit 22 stays clear: permit and link are not both set yet
    xfer(1, 8'h50, 32'hffbfffff, 2'h0);
    xfer(0, 8'h54, 32'h40000000, 2'h0);
    chk("swap", swp, 1);
    xfer(1, 8'h54, 32'h40000000, 2'h0);
    chk("swap", swp, 0);
    // Lane 3 off: bit 30 must not move
    ws <= 4'h7;
    xfer(1, 8'h50, 32'h40000000, 2'h0);
    chk("swap", swp, 0);
    ws <= 4'hf;
    evt(0, 32'h0, 1);
    chk("permit", prm, 1);
    xfer(0, 8'h50, 32'h00800000, 2'h0);
    xfer(1, 8'h54, 32'h00800000, 2'h0);
    chk("permit", prm, 0);
    // Unmask failures only; the loader's status bit is still set
    xfer(1, 8'h64, 32'h1, 2'h0);
    chk("irq", irq, 0);
    evt(1, 32'ha96dbeef, 0);
    chk("irq", irq, 1);
    evt(1, 32'h56924110, 0);
    xfer(1, 8'h3c, 32'hffffffff, 2'h0);
    xfer(0, 8'h3c, 32'h56924110, 2'h0);
    xfer(0, 8'h60, 32'h3, 2'h0);
    repeat (2) @(negedge clock);
    chk("irq", irq, 0);
    xfer(1, 8'h64, 32'h0, 2'h0);
    evt(1, 32'h1, 0);
    chk("irq", irq, 0);
    xfer(0, 8'h3c, 32'h1, 2'h0);
    xfer(1, 8'h44, 32'h1, 2'h2);
    xfer(0, 8'h44, 32'h0, 2'h2);
    results;
  end
endmodule // posted_write_error_and_host_control_bench

//--- sim/pw_err_hc_regs_asserts.sv
// Port checker for the error capture and host control block.
// Assumes it is bound to the top module and shares its one clock.
`timescale 1ns/100ps
module pw_err_hc_regs_asserts (
  input wire i_clock,
  input wire i_rst,
  input wire i_s_axi_arvalid,
  input wire o_s_axi_arready,
  input wire o_s_axi_rvalid,
  input wire o_s_axi_bvalid,
  input wire i_s_axi_bready,
  input wire i_pw_fail,
  input wire i_eeprom_load,
  input wire i_eeprom_permit,
  input wire o_swap_disable,
  input wire o_phy_enhance_config_permit,
  input wire o_irq
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Permit flag moves only by loader or a write
  chk_permit_load: assert property (
    i_eeprom_load |=> o_phy_enhance_config_permit == $past(i_eeprom_permit)) else $error("load");
  chk_permit_no_set: assert property (
    $rose(o_phy_enhance_config_permit) |-> $past(i_eeprom_load)) else $error("set");
  chk_permit_clear: assert property (
    $fell(o_phy_enhance_config_permit) |-> $past(i_eeprom_load) || $rose(o_s_axi_bvalid))
    else $error("clear");
  chk_swap_by_write: assert property (
    !$stable(o_swap_disable) |-> $rose(o_s_axi_bvalid)) else $error("swap");
  // Mask write lifts the line on the same edge as its own update
  chk_irq_cause: assert property (
    $rose(o_irq) |-> $past(i_pw_fail) || $past(i_eeprom_load) || o_s_axi_bvalid
      || $past(o_s_axi_bvalid)) else $error("irq");
  chk_read_answer: assert property (
    i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid) else $error("read");
  chk_read_refused: assert property (
    o_s_axi_rvalid |-> !o_s_axi_arready) else $error("arready");
  chk_bresp_done: assert property (
    o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid) else $error("bvalid");
  cover property (i_pw_fail ##1 o_irq);
  cover property (i_eeprom_load ##1 o_phy_enhance_config_permit);
  cover property ($fell(o_swap_disable));
endmodule // pw_err_hc_regs_asserts
bind pw_err_hc_regs pw_err_hc_regs_asserts u_pw_err_hc_regs_asserts (.*);
